// ### common/ovp_alarm_pkg.sv
package ovp_alarm_pkg;

	// ----------------------------------------
	// Cell stack and time base
	// ----------------------------------------
	localparam int CELL_COUNT = 14;
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 12;

	// ----------------------------------------
	// Delays and periods, in milliseconds
	// ----------------------------------------
	localparam int DETECT_DELAY_MS = 2000;
	localparam int RELEASE_DELAY_MS = 200;
	localparam int NORMAL_SAMPLE_PERIOD_MS = 400;
	localparam int ALARM_SAMPLE_PERIOD_MS = 100;
	localparam int TEST_DETECT_DELAY_MS = 100;
	localparam int TEST_RELEASE_DELAY_MS = 100;
	localparam int TEST_ENTRY_TIME_MS = 25;

	// Each tick lasts one millisecond, so these are tick counts.
	localparam int MS_PER_TICK = TICK_PERIOD_NS / 1000000;
	localparam logic [TIMER_W-1:0] DETECT_TICKS = TIMER_W'(DETECT_DELAY_MS / MS_PER_TICK);
	localparam logic [TIMER_W-1:0] RELEASE_TICKS = TIMER_W'(RELEASE_DELAY_MS / MS_PER_TICK);
	localparam logic [TIMER_W-1:0] NORMAL_PERIOD_TICKS =
		TIMER_W'(NORMAL_SAMPLE_PERIOD_MS / MS_PER_TICK);
	localparam logic [TIMER_W-1:0] ALARM_PERIOD_TICKS =
		TIMER_W'(ALARM_SAMPLE_PERIOD_MS / MS_PER_TICK);
	localparam logic [TIMER_W-1:0] TEST_DETECT_TICKS =
		TIMER_W'(TEST_DETECT_DELAY_MS / MS_PER_TICK);
	localparam logic [TIMER_W-1:0] TEST_RELEASE_TICKS =
		TIMER_W'(TEST_RELEASE_DELAY_MS / MS_PER_TICK);
	localparam logic [TIMER_W-1:0] TEST_ENTRY_TICKS = TIMER_W'(TEST_ENTRY_TIME_MS / MS_PER_TICK);
	localparam logic [1:0] CLEAR_SAMPLES = 2'h2;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] CONFIG_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0C;
	localparam logic CONFIG_RESET = 1'h1;
	localparam int IRQ_W = 3;
	localparam int IRQ_ALARM_BIT = 0;
	localparam int IRQ_RELEASE_BIT = 1;
	localparam int IRQ_TEST_BIT = 2;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

	typedef enum logic [1:0] {
		ST_NORMAL = 2'b00,
		ST_DETECT = 2'b01,
		ST_ALARM = 2'b10,
		ST_RELEASE = 2'b11
	} ov_state_e;

	typedef struct packed {
		logic pushPull;
		logic openDrainNOut;
		logic openDrainNOe;
	} alarm_pins_s;

endpackage : ovp_alarm_pkg

// ### hdl/tick_gen.sv
`timescale 1ns/1ps
module tick_gen #(
	parameter int unsigned CYCLES = 250000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Time base
	output logic tick
);
	localparam int CW = $clog2(CYCLES);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_q;
	logic wrap;

	assign wrap = (cnt_q == LAST);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else begin
			cnt_q <= wrap ? '0 : cnt_q + 1'b1; // see R13
			tick <= wrap;
		end
	end

	chk_tick_spacing: assert property (@(posedge clk) disable iff (rst) // see R13
		tick |=> !tick)
		else $error("tick pulses back to back");
endmodule : tick_gen

// ### hdl/cell_scan.sv
`timescale 1ns/1ps
module cell_scan #(
	parameter int CELLS = 14
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Scan control
	input wire logic start,
	input wire logic [CELLS-1:0] cells,
	output logic done,
	output logic anyOver
);
	localparam int IW = $clog2(CELLS);
	localparam logic [IW-1:0] TOP = IW'(CELLS - 1);

	logic busy_q;
	logic acc_q;
	logic [IW-1:0] idx_q;
	logic hit;

	assign hit = acc_q | cells[idx_q];

	// One cell per clock, bottom of the stack first.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
			acc_q <= 1'b0;
			idx_q <= '0;
			done <= 1'b0;
			anyOver <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy_q) begin
				if (start) begin
					busy_q <= 1'b1;
					acc_q <= 1'b0;
					idx_q <= '0;
				end
			end else if (idx_q == TOP) begin
				busy_q <= 1'b0;
				done <= 1'b1;
				anyOver <= hit; // see R14
			end else begin
				acc_q <= hit;
				idx_q <= idx_q + 1'b1; // see R12
			end
		end
	end

	chk_scan_order: assert property (@(posedge clk) disable iff (rst) // see R12
		busy_q && idx_q != TOP |=> busy_q && idx_q == $past(idx_q) + 1'b1)
		else $error("cells not scanned upward");
endmodule : cell_scan

// ### hdl/ovp_alarm_timer.sv
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// R1: normal releases open drain, overvoltage drives both.
// R2: force input low shows overvoltage outputs.
// R3: alarm only after detection delay elapsed.
// R4: release only after release delay elapsed.
// R5: sample every 400 ms, 100 ms when alarming. The code also samples every 100 ms in detect and in quick test.
// R6: quick test uses 100 ms delays.
// R7: quick test after force low 25 ms.
// R8: delays may lag by one monitor cycle.
// R9: top cell inactive ignores all overvoltage.
// R10: start timer on hit, reset after two clears.
// R11: other side holds force low; high-low exits.
// R12: cells evaluated bottom to top each cycle.
// R13: free-running tick drives every timing.
// R14: fourteen one-bit cell results, sampled per cycle.
module ovp_alarm_timer #(
	parameter int unsigned TICK_CYCLES = ovp_alarm_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Cell comparators and pins
	input wire logic [ovp_alarm_pkg::CELL_COUNT-1:0] cellOver,
	input wire logic topCellActive,
	input wire logic forceAlarmN,
	// Alarm pins
	output ovp_alarm_pkg::alarm_pins_s alarmPins,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Interrupt
	output logic irq
);
	localparam int TW = ovp_alarm_pkg::TIMER_W;
	localparam int NC = ovp_alarm_pkg::CELL_COUNT;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [NC-1:0] cellMeta_q, cellSync_q;
	logic forceMeta_q, forceNSync_q;
	logic topMeta_q, topSync_q;
	logic [1:0] syncFill_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cellMeta_q <= '0;
			cellSync_q <= '0;
			forceMeta_q <= 1'b1;
			forceNSync_q <= 1'b1;
			topMeta_q <= 1'b0;
			topSync_q <= 1'b0;
			syncFill_q <= 2'b00;
		end else begin
			cellMeta_q <= cellOver;
			cellSync_q <= cellMeta_q;
			forceMeta_q <= forceAlarmN;
			forceNSync_q <= forceMeta_q;
			topMeta_q <= topCellActive;
			topSync_q <= topMeta_q;
			syncFill_q <= {syncFill_q[0], 1'b1};
		end
	end

	// ----------------------------------------
	// Time base and cell scan
	// ----------------------------------------
	logic tick, scanDone, anyOver;
	logic sampleStart;

	tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
		.clk(clk),
		.rst(rst),
		.tick(tick)
	);

	cell_scan #(.CELLS(NC)) u_scan (
		.clk(clk),
		.rst(rst),
		.start(sampleStart),
		.cells(cellSync_q),
		.done(scanDone),
		.anyOver(anyOver)
	);

	// ----------------------------------------
	// Quick test mode
	// ----------------------------------------
	logic testMode_q, armed_q, sawHigh_q;
	logic [TW-1:0] entryCnt_q;
	logic entryReached, testEnter, testExit;

	assign entryReached = armed_q && tick && entryCnt_q >= ovp_alarm_pkg::TEST_ENTRY_TICKS - 1'b1;
	assign testEnter = entryReached && !forceNSync_q && !testMode_q; // see R7
	assign testExit = testMode_q && sawHigh_q && !forceNSync_q; // see R11

	// Entry is armed only while the force input has stayed low since reset.
	// The synchroniser's reset value is not a real high, so it counts only once filled.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b1;
			entryCnt_q <= '0;
			testMode_q <= 1'b0;
			sawHigh_q <= 1'b0;
		end else begin
			if (syncFill_q[1] && forceNSync_q) begin
				armed_q <= 1'b0;
			end else if (testEnter) begin
				armed_q <= 1'b0;
			end
			if (armed_q && tick) begin
				entryCnt_q <= entryCnt_q + 1'b1;
			end
			if (testEnter) begin
				testMode_q <= 1'b1;
			end else if (testExit) begin
				testMode_q <= 1'b0;
			end
			sawHigh_q <= testMode_q && !testExit && (sawHigh_q || forceNSync_q);
		end
	end

	// ----------------------------------------
	// Registers written by software
	// ----------------------------------------
	logic monitorEn_q;
	logic [ovp_alarm_pkg::IRQ_W-1:0] irqStatus_q, irqMask_q, irqEvent;

	// ----------------------------------------
	// Monitor cycle and delay timers
	// ----------------------------------------
	ovp_alarm_pkg::ov_state_e state_q, state_d;
	logic [TW-1:0] periodCnt_q, periodLim, timer_q, detLim, relLim;
	logic [1:0] clearCnt_q, clearCnt_d;
	logic evaluate, timerRun, timerClr;

	assign evaluate = monitorEn_q && topSync_q; // see R9
	assign periodLim = (testMode_q || state_q != ovp_alarm_pkg::ST_NORMAL)
		? ovp_alarm_pkg::ALARM_PERIOD_TICKS : ovp_alarm_pkg::NORMAL_PERIOD_TICKS; // see R5
	assign detLim = testMode_q ? ovp_alarm_pkg::TEST_DETECT_TICKS
		: ovp_alarm_pkg::DETECT_TICKS; // see R6
	assign relLim = testMode_q ? ovp_alarm_pkg::TEST_RELEASE_TICKS
		: ovp_alarm_pkg::RELEASE_TICKS; // see R6
	assign sampleStart = tick && periodCnt_q >= periodLim - 1'b1;
	assign timerRun = state_q == ovp_alarm_pkg::ST_DETECT || state_q == ovp_alarm_pkg::ST_RELEASE;
	assign timerClr = state_d != state_q;

	// Delays are only judged when a scan finishes, hence up to one cycle late.
	always_comb begin
		state_d = state_q;
		clearCnt_d = clearCnt_q;
		if (!evaluate) begin
			state_d = ovp_alarm_pkg::ST_NORMAL; // see R9
			clearCnt_d = 2'h0;
		end else if (scanDone) begin // see R8
			case (state_q)
				ovp_alarm_pkg::ST_NORMAL: begin
					clearCnt_d = 2'h0;
					if (anyOver) begin
						state_d = ovp_alarm_pkg::ST_DETECT; // see R10
					end
				end
				ovp_alarm_pkg::ST_DETECT: begin
					if (anyOver) begin
						clearCnt_d = 2'h0;
					end else begin
						clearCnt_d = clearCnt_q + 2'h1;
					end
					if (!anyOver && clearCnt_d == ovp_alarm_pkg::CLEAR_SAMPLES) begin
						state_d = ovp_alarm_pkg::ST_NORMAL; // see R10
					end else if (timer_q >= detLim) begin
						state_d = ovp_alarm_pkg::ST_ALARM; // see R3
					end
				end
				ovp_alarm_pkg::ST_ALARM: begin
					if (!anyOver) begin
						state_d = ovp_alarm_pkg::ST_RELEASE;
					end
				end
				ovp_alarm_pkg::ST_RELEASE: begin
					if (anyOver) begin
						state_d = ovp_alarm_pkg::ST_ALARM;
					end else if (timer_q >= relLim) begin
						state_d = ovp_alarm_pkg::ST_NORMAL; // see R4
					end
				end
				default: begin
					state_d = ovp_alarm_pkg::ST_NORMAL;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ovp_alarm_pkg::ST_NORMAL;
			clearCnt_q <= 2'h0;
			periodCnt_q <= '0;
			timer_q <= '0;
		end else begin
			state_q <= state_d;
			clearCnt_q <= clearCnt_d;
			if (sampleStart) begin
				periodCnt_q <= '0;
			end else if (tick) begin
				periodCnt_q <= periodCnt_q + 1'b1;
			end
			if (timerClr) begin
				timer_q <= '0;
			end else if (timerRun && tick && timer_q != '1) begin
				timer_q <= timer_q + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Alarm outputs
	// ----------------------------------------
	logic alarmOn;

	assign alarmOn = state_q == ovp_alarm_pkg::ST_ALARM || state_q == ovp_alarm_pkg::ST_RELEASE
		|| !forceNSync_q; // see R2

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alarmPins <= '0;
		end else begin
			alarmPins.pushPull <= alarmOn; // see R1
			alarmPins.openDrainNOut <= 1'b0;
			alarmPins.openDrainNOe <= alarmOn; // see R1
		end
	end

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	logic accept, wrPend_q, rdPend_q;
	logic [7:0] addr_q;
	logic [31:0] rdMux;
	logic [ovp_alarm_pkg::IRQ_W-1:0] irqClr;

	assign accept = hsel && hready && htrans[1];
	assign irqClr = (wrPend_q && addr_q == ovp_alarm_pkg::IRQ_STATUS_OFFSET)
		? hwdata[ovp_alarm_pkg::IRQ_W-1:0] : '0;

	always_comb begin
		case (addr_q)
			ovp_alarm_pkg::CONFIG_OFFSET: rdMux = {31'h0000_0000, monitorEn_q};
			ovp_alarm_pkg::STATUS_OFFSET: rdMux = {26'h000_0000, topSync_q, testMode_q,
				alarmPins.pushPull, !forceNSync_q, state_q};
			ovp_alarm_pkg::IRQ_STATUS_OFFSET: rdMux = {29'h0000_0000, irqStatus_q};
			ovp_alarm_pkg::IRQ_MASK_OFFSET: rdMux = {29'h0000_0000, irqMask_q};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	// Reads take one wait state so that a preceding write is always seen.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPend_q <= 1'b0;
			rdPend_q <= 1'b0;
			addr_q <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wrPend_q <= accept && hwrite;
			rdPend_q <= accept && !hwrite;
			hreadyout <= !(accept && !hwrite);
			if (accept) begin
				addr_q <= haddr[7:0];
			end
			if (rdPend_q) begin
				hrdata <= rdMux;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			monitorEn_q <= ovp_alarm_pkg::CONFIG_RESET;
			irqMask_q <= ovp_alarm_pkg::IRQ_MASK_RESET;
		end else if (wrPend_q) begin
			if (addr_q == ovp_alarm_pkg::CONFIG_OFFSET) begin
				monitorEn_q <= hwdata[0];
			end
			if (addr_q == ovp_alarm_pkg::IRQ_MASK_OFFSET) begin
				irqMask_q <= hwdata[ovp_alarm_pkg::IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	assign irqEvent[ovp_alarm_pkg::IRQ_ALARM_BIT] = state_d == ovp_alarm_pkg::ST_ALARM
		&& state_q == ovp_alarm_pkg::ST_DETECT;
	assign irqEvent[ovp_alarm_pkg::IRQ_RELEASE_BIT] = state_d == ovp_alarm_pkg::ST_NORMAL
		&& (state_q == ovp_alarm_pkg::ST_ALARM || state_q == ovp_alarm_pkg::ST_RELEASE);
	assign irqEvent[ovp_alarm_pkg::IRQ_TEST_BIT] = testEnter;

	// A new event wins over a clear in the same cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqStatus_q <= '0;
			irq <= 1'b0;
		end else begin
			irqStatus_q <= (irqStatus_q & ~irqClr) | irqEvent;
			irq <= |(((irqStatus_q & ~irqClr) | irqEvent) & irqMask_q);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence seqDetectDone;
		state_q == ovp_alarm_pkg::ST_DETECT ##1 state_q == ovp_alarm_pkg::ST_ALARM;
	endsequence

	sequence seqReleaseDone;
		state_q == ovp_alarm_pkg::ST_RELEASE ##1 state_q == ovp_alarm_pkg::ST_NORMAL;
	endsequence

	chk_force_alarm_out: assert property ( // see R2
		!forceNSync_q |=> alarmPins.pushPull && alarmPins.openDrainNOe)
		else $error("force low did not raise alarms");
	chk_normal_outputs: assert property ( // see R1
		state_q == ovp_alarm_pkg::ST_NORMAL && forceNSync_q
		|=> !alarmPins.pushPull && !alarmPins.openDrainNOe && !alarmPins.openDrainNOut)
		else $error("alarm shown in normal state");
	chk_detect_delay: assert property ( // see R3
		seqDetectDone |-> $past(evaluate) && $past(timer_q) >= $past(detLim))
		else $error("alarm before detection delay");
	chk_release_delay: assert property ( // see R4
		seqReleaseDone |-> !$past(evaluate) || $past(timer_q) >= $past(relLim))
		else $error("release before release delay");
	chk_fast_period: assert property ( // see R5
		sampleStart && state_q != ovp_alarm_pkg::ST_NORMAL
		|-> periodCnt_q == ovp_alarm_pkg::ALARM_PERIOD_TICKS - 1'b1)
		else $error("wrong monitor period in alarm");
	chk_test_entry: assert property ( // see R7
		$rose(testMode_q) |-> $past(entryCnt_q) == ovp_alarm_pkg::TEST_ENTRY_TICKS - 1'b1)
		else $error("test mode entered at wrong time");
	chk_inactive_ignore: assert property ( // see R9
		!topSync_q |=> state_q == ovp_alarm_pkg::ST_NORMAL)
		else $error("evaluation while top cell inactive");
	chk_two_clears: assert property ( // see R10
		state_q == ovp_alarm_pkg::ST_DETECT && clearCnt_q == 2'h1 && scanDone && !anyOver
		|=> state_q == ovp_alarm_pkg::ST_NORMAL && timer_q == '0)
		else $error("detect timer not reset on two clears");
	chk_test_delays: assert property ( // see R6
		testMode_q |-> detLim == ovp_alarm_pkg::TEST_DETECT_TICKS
		&& periodLim == ovp_alarm_pkg::ALARM_PERIOD_TICKS)
		else $error("quick test timing not applied");
endmodule : ovp_alarm_timer

// ### verif/pack_ctrl_model.sv
`timescale 1ns/1ps
module pack_ctrl_model (
	// Clock
	input wire logic clk,
	// Device pins
	input wire ovp_alarm_pkg::alarm_pins_s alarmPins,
	output logic [ovp_alarm_pkg::CELL_COUNT-1:0] cellOver,
	output logic topCellActive,
	output logic forceAlarmN,
	// Pack side view of the open-drain line
	output logic ovnLevel
);
	// The open-drain line carries a pull-up, so a released line reads high.
	assign ovnLevel = alarmPins.openDrainNOe ? alarmPins.openDrainNOut : 1'h1;

	initial begin
		cellOver = '0;
		topCellActive = 1'h0;
		forceAlarmN = 1'h1;
	end

	// Holding forceN low across reset asks for quick test; high then low leaves it.
	task drive(input logic [ovp_alarm_pkg::CELL_COUNT-1:0] cells, input logic top,
		input logic forceN);
		@(posedge clk);
		cellOver <= cells;
		topCellActive <= top;
		forceAlarmN <= forceN;
	endtask : drive
endmodule : pack_ctrl_model

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int TC = 10;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hrdata;
	logic [31:0] d;
	logic hreadyout;
	logic hresp;
	logic irq;
	ovp_alarm_pkg::alarm_pins_s alarmPins;
	logic [ovp_alarm_pkg::CELL_COUNT-1:0] cellOver;
	logic topCellActive;
	logic forceAlarmN;
	logic ovnLevel;
	int mismatches = 0;
	int checked = 0;

	always #2 clk = ~clk;

	pack_ctrl_model pack (.clk(clk), .alarmPins(alarmPins), .cellOver(cellOver),
		.topCellActive(topCellActive), .forceAlarmN(forceAlarmN), .ovnLevel(ovnLevel));

	ovp_alarm_timer #(.TICK_CYCLES(TC)) i_ovp_alarm_timer (.clk(clk), .rst(rst),
		.cellOver(cellOver), .topCellActive(topCellActive), .forceAlarmN(forceAlarmN),
		.alarmPins(alarmPins), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq(irq));

	task finish_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task do_reset;
		@(posedge clk);
		rst <= 1'h1;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
	endtask : do_reset

	task cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : cyc

	// The level seen at a falling edge is the one sampled at the next rising edge.
	task wait_ready(output logic [31:0] data);
		int n;
		logic r;
		n = 0;
		do begin
			@(negedge clk);
			r = hreadyout;
			data = hrdata;
			@(posedge clk);
			n++;
			if (n > 50) begin
				mismatches++;
				finish_test();
			end
		end while (r !== 1'h1);
	endtask : wait_ready

	task bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'h1;
		haddr <= 32'(a);
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		wait_ready(d);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready(d);
	endtask : bus

	task measure(input logic lvl, input int lo, input int hi);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
			if (n > hi * TC + 100) begin
				mismatches++;
				finish_test();
			end
		end while (alarmPins.pushPull !== lvl);
		check(32'(n >= lo * TC && n <= hi * TC), 32'h0000_0001);
	endtask : measure

	task check_pins(input logic alarm);
		check(alarmPins.pushPull, alarm);
		check(ovnLevel, !alarm);
		check(alarmPins.openDrainNOe, alarm);
	endtask : check_pins

	task scen_reset;
		check_pins(1'h0);
		check(irq, 1'h0);
		bus(ovp_alarm_pkg::CONFIG_OFFSET, 1'h0, 32'h0000_0000);
		check(d, 32'h0000_0001);
		bus(ovp_alarm_pkg::IRQ_MASK_OFFSET, 1'h1, 32'h0000_0007);
		bus(ovp_alarm_pkg::IRQ_MASK_OFFSET, 1'h0, 32'h0000_0000);
		check(d, 32'h0000_0007);
		bus(ovp_alarm_pkg::IRQ_MASK_OFFSET, 1'h1, 32'h0000_0001);
		bus(8'h40, 1'h0, 32'h0000_0000);
		check(d, 32'h0000_0000);
		check(hresp, 1'h0);
	endtask : scen_reset

	task scen_force;
		pack.drive('0, 1'h0, 1'h0);
		cyc(4);
		check_pins(1'h1);
		cyc(40 * TC);
		bus(ovp_alarm_pkg::STATUS_OFFSET, 1'h0, 32'h0000_0000);
		check(d[5:2], 4'h3);
		pack.drive('0, 1'h0, 1'h1);
		cyc(4);
		check_pins(1'h0);
	endtask : scen_force

	task scen_clear;
		time t0;
		int n;
		n = 0;
		pack.drive(14'h0001, 1'h1, 1'h1);
		t0 = $time;
		do begin
			bus(ovp_alarm_pkg::STATUS_OFFSET, 1'h0, 32'h0000_0000);
			n++;
			if (n > 2000) begin
				mismatches++;
				finish_test();
			end
		end while (d[1:0] !== 2'h1);
		check(32'(($time - t0) <= (ovp_alarm_pkg::NORMAL_PERIOD_TICKS + 3) * TC * 4), 32'h1);
		pack.drive('0, 1'h1, 1'h1);
		cyc((2 * ovp_alarm_pkg::ALARM_PERIOD_TICKS + 3) * TC);
		bus(ovp_alarm_pkg::STATUS_OFFSET, 1'h0, 32'h0000_0000);
		check(d[1:0], 2'h0);
		check_pins(1'h0);
		bus(ovp_alarm_pkg::CONFIG_OFFSET, 1'h1, 32'h0000_0000);
		pack.drive(14'h0001, 1'h1, 1'h1);
		cyc(500 * TC);
		bus(ovp_alarm_pkg::STATUS_OFFSET, 1'h0, 32'h0000_0000);
		check(d[1:0], 2'h0);
		check_pins(1'h0);
		pack.drive('0, 1'h1, 1'h1);
		cyc(20);
		bus(ovp_alarm_pkg::CONFIG_OFFSET, 1'h1, 32'h0000_0001);
		bus(ovp_alarm_pkg::CONFIG_OFFSET, 1'h0, 32'h0000_0000);
		check(d, 32'h0000_0001);
	endtask : scen_clear

	task scen_detect;
		pack.drive(14'h2000, 1'h0, 1'h1);
		cyc(2600 * TC);
		check_pins(1'h0);
		pack.drive(14'h2000, 1'h1, 1'h1);
		measure(1'h1, ovp_alarm_pkg::DETECT_TICKS, 2503);
		check_pins(1'h1);
		cyc(2);
		check(irq, 1'h1);
		bus(ovp_alarm_pkg::STATUS_OFFSET, 1'h0, 32'h0000_0000);
		check(d[3:0], 4'ha);
		bus(ovp_alarm_pkg::IRQ_STATUS_OFFSET, 1'h1, 32'h0000_0001);
		cyc(2);
		check(irq, 1'h0);
	endtask : scen_detect

	task scen_release;
		pack.drive('0, 1'h1, 1'h1);
		measure(1'h0, ovp_alarm_pkg::RELEASE_TICKS, 403);
		check_pins(1'h0);
		cyc(2);
		check(irq, 1'h0);
		bus(ovp_alarm_pkg::IRQ_MASK_OFFSET, 1'h1, 32'h0000_0002);
		cyc(2);
		check(irq, 1'h1);
		bus(ovp_alarm_pkg::IRQ_STATUS_OFFSET, 1'h1, 32'h0000_0002);
		cyc(2);
		check(irq, 1'h0);
	endtask : scen_release

	task scen_quick;
		pack.drive('0, 1'h0, 1'h0);
		do_reset();
		cyc(10 * TC);
		bus(ovp_alarm_pkg::STATUS_OFFSET, 1'h0, 32'h0000_0000);
		check(d[4], 1'h0);
		cyc(30 * TC);
		bus(ovp_alarm_pkg::STATUS_OFFSET, 1'h0, 32'h0000_0000);
		check(d[4], 1'h1);
		bus(ovp_alarm_pkg::IRQ_STATUS_OFFSET, 1'h0, 32'h0000_0000);
		check(d[2], 1'h1);
		pack.drive('0, 1'h1, 1'h1);
		cyc(4);
		check_pins(1'h0);
		pack.drive(14'h0001, 1'h1, 1'h1);
		measure(1'h1, ovp_alarm_pkg::TEST_DETECT_TICKS, 303);
		pack.drive('0, 1'h1, 1'h1);
		measure(1'h0, ovp_alarm_pkg::TEST_RELEASE_TICKS, 303);
		pack.drive('0, 1'h1, 1'h0);
		cyc(4);
		pack.drive('0, 1'h1, 1'h1);
		cyc(4);
		bus(ovp_alarm_pkg::STATUS_OFFSET, 1'h0, 32'h0000_0000);
		check(d[4], 1'h0);
	endtask : scen_quick

	initial begin
		do_reset();
		scen_reset();
		scen_force();
		scen_clear();
		scen_detect();
		scen_release();
		scen_quick();
		finish_test();
	end
endmodule : testbench
